// File: rtl/opd_params.svh
// opcode decoder constants: encodings, field positions, register map
`ifndef OPD_PARAMS_SVH
`define OPD_PARAMS_SVH
// ==========================================================
// register map (byte addresses)
`define OPD_REG_CTRL      4'h0
`define OPD_REG_BYTES     4'h4
`define OPD_REG_RESULT    4'h8
`define OPD_REG_STATUS    4'hC
`define OPD_CTRL_RESET    32'h0000_0000
// ==========================================================
// addressing byte fields
`define OPD_MOD_REG       2'h3
`define OPD_MOD_NODISP    2'h0
`define OPD_MOD_DISP8     2'h1
`define OPD_RM_DIRECT     3'h6
// ==========================================================
// single full-byte opcodes
`define OPD_OP_SEG_TO     8'h8E
`define OPD_OP_SEG_FROM   8'h8C
`define OPD_OP_TABLE_LOOKUP_BYTE_T     8'hD7
`define OPD_OP_EA         8'h8D
`define OPD_OP_PTR_DS     8'hC5
`define OPD_OP_PTR_ES     8'hC4
`define OPD_OP_FL2AH      8'h9F
`define OPD_OP_AH2FL      8'h9E
`define OPD_OP_AADD       8'h37
`define OPD_OP_ASUB       8'h3F
`define OPD_OP_BSUB       8'h2F
`define OPD_OP_AMUL       8'hD4
`define OPD_OP_ADIV       8'hD5
`define OPD_OP_ASC_BASE   8'h0A
`define OPD_OP_B2W        8'h98
`define OPD_OP_W2D        8'h99
// ==========================================================
// prefixes: six-bit and seven-bit
`define OPD_P6_ADC        6'h04
`define OPD_P6_SUB        6'h0A
`define OPD_P6_SBB        6'h06
`define OPD_P7_SBB_ACC    7'h0E
`define OPD_P7_GRP3       7'h7B
`define OPD_P6_SHIFT      6'h34
`define OPD_P7_SCOPY      7'h52
`define OPD_P7_SCMP       7'h53
`define OPD_P7_SSCAN      7'h57
`define OPD_P7_SLOAD      7'h56
`define OPD_P7_SSTORE     7'h55
`define OPD_P7_REP        7'h79
`endif

// File: rtl/opd_pkg.sv
// opcode decoder types
package opd_pkg;
	typedef enum logic [5:0] {
		OPD_NONE = 6'h00, OPD_SEG_LOAD = 6'h01, OPD_SEG_STORE = 6'h02,
		OPD_TABLE_LOOKUP_BYTE = 6'h03, OPD_EFFECTIVE_ADDR_LOAD = 6'h04,
		OPD_FAR_PTR_VIA_DATA_SEG = 6'h05, OPD_FAR_PTR_VIA_EXTRA_SEG = 6'h06,
		OPD_FLAGS_TO_HIGH_ACC = 6'h07, OPD_HIGH_ACC_TO_FLAGS = 6'h08,
		OPD_ADD_CARRY = 6'h09, OPD_MINUS = 6'h0A, OPD_MINUS_WITH_BORROW = 6'h0B,
		OPD_MINUS_WITH_BORROW_IMM = 6'h0C, OPD_ASCII_ADD_FIXUP = 6'h0D,
		OPD_ASCII_MINUS_FIXUP = 6'h0E, OPD_BCD_MINUS_FIXUP = 6'h0F,
		OPD_ASCII_PRODUCT_FIXUP = 6'h10, OPD_ASCII_QUOTIENT_PREFIXUP = 6'h11,
		OPD_TEST_IMM = 6'h12, OPD_INVERT = 6'h13, OPD_TWOS_COMPLEMENT_OP = 6'h14,
		OPD_UNSIGNED_PRODUCT = 6'h15, OPD_SIGNED_PRODUCT = 6'h16,
		OPD_UNSIGNED_QUOTIENT = 6'h17, OPD_SIGNED_QUOTIENT = 6'h18,
		OPD_ROTATE_LEFTWARD = 6'h19, OPD_ROTATE_RIGHTWARD = 6'h1A,
		OPD_CARRY_ROTATE_LEFT = 6'h1B, OPD_CARRY_ROTATE_RIGHT = 6'h1C,
		OPD_SHIFT_LEFT_OP = 6'h1D, OPD_LOGICAL_RIGHT_SHIFT = 6'h1E,
		OPD_ARITH_RIGHT_SHIFT = 6'h1F, OPD_BYTE_TO_WORD_EXTEND = 6'h20,
		OPD_WORD_TO_DOUBLE_EXTEND = 6'h21, OPD_STRING_COPY = 6'h22,
		OPD_STRING_COMPARE = 6'h23, OPD_STRING_SCAN = 6'h24,
		OPD_STRING_LOAD = 6'h25, OPD_STRING_STORE = 6'h26,
		OPD_ITERATE_PREFIX = 6'h27
	} opd_op_t;
	typedef struct packed {
		logic       valid;
		opd_op_t    op;
		logic       word;
		logic       dir_to_reg;
		logic       count_var;
		logic       modrm_used;
		logic       reg_direct;
		logic [2:0] reg_field;
		logic [2:0] rm_field;
		logic [2:0] length;
	} opd_dec_t;
	typedef enum logic [1:0] {
		OPD_BUS_IDLE = 2'b00, OPD_BUS_RESP = 2'b01
	} opd_bus_state_t;
endpackage : opd_pkg

// File: rtl/opd_decoder.sv
// opcode decoder with AXI4-Lite register access
// What this block does
// - 8E with addressing byte loads a segment register; selector in middle field.
// - 8C with addressing byte stores a segment register to register or memory.
// - D7 alone is table lookup translate of the low accumulator byte.
// - 8D with addressing byte loads the effective address into middle-field register.
// - C5 and C4 load a far pointer via data or extra segment.
// - 9F copies flags to high accumulator byte; 9E the reverse.
// - 000100dw with addressing byte is add with carry.
// - 001010dw with addressing byte is subtraction, direction bit picks destination.
// - 000110dw is register subtract with borrow; 0001110w is accumulator immediate form.
// - 37, 3F, 2F are ascii add, ascii subtract and bcd subtract fixups.
// - D4 0A and D5 0A are two-byte ascii multiply and divide fixups.
// - 1111011w middle field picks test, invert, negate, unsigned or signed multiply.
// - 1111011w middle fields 110 and 111 are unsigned and signed divide.
// - 110100vw middle field picks rotate, carry rotate, shift left, logical or arith right.
// - 98 extends byte to word; 99 extends word to double.
// - string primitives by seven-bit prefix plus width; 1111001z is repeat prefix.
// - width bit one means word operand, zero means byte operand.
// - addressing kind 11 makes the operand field a register number.
// - addressing kind 00 has no displacement except direct address with two bytes.
// - immediate takes two bytes when the width bit is set, else one byte.
`timescale 1ns/1ps
`include "opd_params.svh"
module opd_decoder
	import opd_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ==========================================================
	// decode function
	function automatic opd_dec_t decode(input logic [7:0] b0, input logic [7:0] b1);
		opd_dec_t   d;
		logic [1:0] md;
		logic [2:0] mid;
		logic [2:0] disp;
		logic [2:0] imm;
		d = '0;
		md = b1[7:6];
		mid = b1[5:3];
		imm = 3'd0;
		d.word = b0[0];
		d.dir_to_reg = b0[1];
		d.valid = 1'b1;
		if (b0 == `OPD_OP_SEG_TO && !mid[2]) begin
			d.op = OPD_SEG_LOAD;
			d.modrm_used = 1'b1;
		end else if (b0 == `OPD_OP_SEG_FROM && !mid[2]) begin
			d.op = OPD_SEG_STORE;
			d.modrm_used = 1'b1;
		end else if (b0 == `OPD_OP_TABLE_LOOKUP_BYTE_T) begin
			d.op = OPD_TABLE_LOOKUP_BYTE;
		end else if (b0 == `OPD_OP_EA) begin
			d.op = OPD_EFFECTIVE_ADDR_LOAD;
			d.modrm_used = 1'b1;
		end else if (b0 == `OPD_OP_PTR_DS || b0 == `OPD_OP_PTR_ES) begin
			d.op = b0[0] ? OPD_FAR_PTR_VIA_DATA_SEG : OPD_FAR_PTR_VIA_EXTRA_SEG;
			d.modrm_used = 1'b1;
		end else if (b0 == `OPD_OP_FL2AH) begin
			d.op = OPD_FLAGS_TO_HIGH_ACC;
		end else if (b0 == `OPD_OP_AH2FL) begin
			d.op = OPD_HIGH_ACC_TO_FLAGS;
		end else if (b0[7:2] == `OPD_P6_ADC) begin
			d.op = OPD_ADD_CARRY;
			d.modrm_used = 1'b1;
		end else if (b0[7:2] == `OPD_P6_SUB) begin
			d.op = OPD_MINUS;
			d.modrm_used = 1'b1;
		end else if (b0[7:2] == `OPD_P6_SBB) begin
			d.op = OPD_MINUS_WITH_BORROW;
			d.modrm_used = 1'b1;
		end else if (b0[7:1] == `OPD_P7_SBB_ACC) begin
			d.op = OPD_MINUS_WITH_BORROW_IMM;
			d.dir_to_reg = 1'b0;
			imm = b0[0] ? 3'd2 : 3'd1;
		end else if (b0 == `OPD_OP_AADD) begin
			d.op = OPD_ASCII_ADD_FIXUP;
		end else if (b0 == `OPD_OP_ASUB) begin
			d.op = OPD_ASCII_MINUS_FIXUP;
		end else if (b0 == `OPD_OP_BSUB) begin
			d.op = OPD_BCD_MINUS_FIXUP;
		end else if ((b0 == `OPD_OP_AMUL || b0 == `OPD_OP_ADIV) && b1 == `OPD_OP_ASC_BASE) begin
			// second byte is part of the instruction, not an addressing byte
			d.op = b0[0] ? OPD_ASCII_QUOTIENT_PREFIXUP : OPD_ASCII_PRODUCT_FIXUP;
			imm = 3'd1;
		end else if (b0[7:1] == `OPD_P7_GRP3) begin
			d.modrm_used = 1'b1;
			case (mid)
				3'b000: begin
					d.op = OPD_TEST_IMM;
					imm = b0[0] ? 3'd2 : 3'd1;
				end
				3'b010: d.op = OPD_INVERT;
				3'b011: d.op = OPD_TWOS_COMPLEMENT_OP;
				3'b100: d.op = OPD_UNSIGNED_PRODUCT;
				3'b101: d.op = OPD_SIGNED_PRODUCT;
				3'b110: d.op = OPD_UNSIGNED_QUOTIENT;
				3'b111: d.op = OPD_SIGNED_QUOTIENT;
				default: d.valid = 1'b0;
			endcase
		end else if (b0[7:2] == `OPD_P6_SHIFT) begin
			d.modrm_used = 1'b1;
			d.count_var = b0[1];
			case (mid)
				3'b000: d.op = OPD_ROTATE_LEFTWARD;
				3'b001: d.op = OPD_ROTATE_RIGHTWARD;
				3'b010: d.op = OPD_CARRY_ROTATE_LEFT;
				3'b011: d.op = OPD_CARRY_ROTATE_RIGHT;
				3'b100: d.op = OPD_SHIFT_LEFT_OP;
				3'b101: d.op = OPD_LOGICAL_RIGHT_SHIFT;
				3'b111: d.op = OPD_ARITH_RIGHT_SHIFT;
				default: d.valid = 1'b0;
			endcase
		end else if (b0 == `OPD_OP_B2W) begin
			d.op = OPD_BYTE_TO_WORD_EXTEND;
		end else if (b0 == `OPD_OP_W2D) begin
			d.op = OPD_WORD_TO_DOUBLE_EXTEND;
		end else if (b0[7:1] == `OPD_P7_SCOPY) begin
			d.op = OPD_STRING_COPY;
		end else if (b0[7:1] == `OPD_P7_SCMP) begin
			d.op = OPD_STRING_COMPARE;
		end else if (b0[7:1] == `OPD_P7_SSCAN) begin
			d.op = OPD_STRING_SCAN;
		end else if (b0[7:1] == `OPD_P7_SLOAD) begin
			d.op = OPD_STRING_LOAD;
		end else if (b0[7:1] == `OPD_P7_SSTORE) begin
			d.op = OPD_STRING_STORE;
		end else if (b0[7:1] == `OPD_P7_REP) begin
			d.op = OPD_ITERATE_PREFIX;
		end else begin
			d.valid = 1'b0;
		end
		// displacement bytes from the addressing kind
		if (!d.modrm_used) begin
			disp = 3'd0;
		end else if (md == `OPD_MOD_REG) begin
			disp = 3'd0;
		end else if (md == `OPD_MOD_NODISP) begin
			disp = (b1[2:0] == `OPD_RM_DIRECT) ? 3'd2 : 3'd0;
		end else if (md == `OPD_MOD_DISP8) begin
			disp = 3'd1;
		end else begin
			disp = 3'd2;
		end
		d.reg_direct = d.modrm_used && md == `OPD_MOD_REG;
		d.reg_field = d.modrm_used ? mid : 3'd0;
		d.rm_field = d.modrm_used ? b1[2:0] : 3'd0;
		if (!d.valid) begin
			d = '0;
		end else begin
			d.length = 3'd1 + {2'b00, d.modrm_used} + disp + imm;
		end
		return d;
	endfunction : decode

	// ==========================================================
	// registers
	logic [15:0]    bytes_q;
	logic [15:0]    bytes_d;
	logic           snap_en_q;
	logic           snap_en_d;
	opd_dec_t       result_q;
	opd_dec_t       result_d;
	logic [7:0]     count_q;
	logic [7:0]     count_d;
	opd_dec_t       live_dec;
	opd_bus_state_t wr_state_q;
	opd_bus_state_t rd_state_q;
	logic           aw_held_q;
	logic [3:0]     aw_addr_q;
	logic           w_held_q;
	logic [31:0]    w_data_q;
	logic [3:0]     w_strb_q;

	// ==========================================================
	// write path: address and data taken in either order
	wire aw_take  = s_axi_awvalid && s_axi_awready;
	wire w_take   = s_axi_wvalid && s_axi_wready;
	wire have_aw  = aw_held_q || aw_take;
	wire have_w   = w_held_q || w_take;
	wire [3:0]  wr_addr = aw_take ? s_axi_awaddr : aw_addr_q;
	wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_q;
	wire [3:0]  wr_strb = w_take ? s_axi_wstrb : w_strb_q;
	wire wr_fire  = wr_state_q == OPD_BUS_IDLE && have_aw && have_w;
	wire wr_ctrl  = wr_fire && wr_addr == `OPD_REG_CTRL;
	wire wr_bytes = wr_fire && wr_addr == `OPD_REG_BYTES;
	wire wr_ok    = wr_ctrl || wr_bytes;

	// decode of the loaded byte pair; a new pair updates the result while capture is enabled
	assign live_dec  = decode(bytes_q[7:0], bytes_q[15:8]);
	assign bytes_d   = {wr_strb[1] ? wr_data[15:8] : bytes_q[15:8],
		wr_strb[0] ? wr_data[7:0] : bytes_q[7:0]};
	assign snap_en_d = wr_ctrl && wr_strb[0] ? wr_data[0] : snap_en_q;
	// result follows the bytes only while capture is enabled
	assign result_d  = snap_en_q ? live_dec : result_q;
	assign count_d   = (snap_en_q && live_dec.valid && result_q != live_dec) ?
		count_q + 8'h01 : count_q;

	// ==========================================================
	// read path
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [31:0] rd_word =
		(s_axi_araddr == `OPD_REG_CTRL)   ? {31'h0, snap_en_q} :
		(s_axi_araddr == `OPD_REG_BYTES)  ? {16'h0, bytes_q} :
		(s_axi_araddr == `OPD_REG_RESULT) ? {{(32 - $bits(opd_dec_t)){1'b0}}, result_q} :
		{24'h0, count_q};
	wire rd_ok = s_axi_araddr == `OPD_REG_CTRL || s_axi_araddr == `OPD_REG_BYTES ||
		s_axi_araddr == `OPD_REG_RESULT || s_axi_araddr == `OPD_REG_STATUS;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bytes_q    <= 16'h0000;
			snap_en_q  <= 1'b0;
			result_q   <= '0;
			count_q    <= 8'h00;
			wr_state_q <= OPD_BUS_IDLE;
			aw_held_q  <= 1'b0;
			aw_addr_q  <= 4'h0;
			w_held_q   <= 1'b0;
			w_data_q   <= 32'h0000_0000;
			w_strb_q   <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			if (wr_bytes) begin
				bytes_q <= bytes_d;
			end
			snap_en_q <= snap_en_d;
			result_q  <= result_d;
			count_q   <= count_d;
			if (aw_take && !wr_fire) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take && !wr_fire) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			s_axi_awready <= !have_aw && wr_state_q == OPD_BUS_IDLE && !s_axi_awready;
			s_axi_wready  <= !have_w && wr_state_q == OPD_BUS_IDLE && !s_axi_wready;
			case (wr_state_q)
				OPD_BUS_IDLE: begin
					if (wr_fire) begin
						aw_held_q    <= 1'b0;
						w_held_q     <= 1'b0;
						s_axi_awready <= 1'b0;
						s_axi_wready  <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
						wr_state_q   <= OPD_BUS_RESP;
					end
				end
				OPD_BUS_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wr_state_q   <= OPD_BUS_IDLE;
					end
				end
				default: wr_state_q <= OPD_BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q    <= OPD_BUS_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			case (rd_state_q)
				OPD_BUS_IDLE: begin
					s_axi_arready <= !ar_take;
					if (ar_take) begin
						s_axi_rvalid <= 1'b1;
						s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
						s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
						rd_state_q   <= OPD_BUS_RESP;
					end
				end
				OPD_BUS_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state_q   <= OPD_BUS_IDLE;
					end
				end
				default: rd_state_q <= OPD_BUS_IDLE;
			endcase
		end
	end
endmodule : opd_decoder

// File: bench/opd_decoder_asserts.sv
// checker for the decoder register port
`timescale 1ns/1ps
module opd_decoder_asserts (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// write side
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// read side
	input wire logic [3:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic ar_go = s_axi_arvalid && s_axi_arready;
	// ==========
	// handshakes
	property p_r_next; ar_go |=> s_axi_rvalid; endproperty
	a_r_next: assert property (p_r_next) else $error("read not answered");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
	property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
	// ==========
	// read contents
	property p_bad_addr;
		ar_go && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("odd address accepted");
	// a valid decode is one to six bytes long; invalid reads all zero
	property p_length;
		ar_go && s_axi_araddr == 4'h8 |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:21] == 11'h0
			&& (s_axi_rdata[20] ? s_axi_rdata[2:0] inside {[3'h1:3'h6]} : s_axi_rdata == 32'h0);
	endproperty
	a_length: assert property (p_length) else $error("bad result shape");
	property p_status; ar_go && s_axi_araddr == 4'hC |=> s_axi_rdata[31:8] == 24'h0; endproperty
	a_status: assert property (p_status) else $error("status too wide");
	c_result: cover property (ar_go && s_axi_araddr == 4'h8);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : opd_decoder_asserts
bind opd_decoder opd_decoder_asserts opd_decoder_asserts_i (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// File: bench/opd_fetch_model.sv
// prefetch queue model handing out opcode byte pairs
`timescale 1ns/1ps
module opd_fetch_model;
	logic [15:0] last_q = 16'h0000;
	// an unfetched second byte never repeats the old one, so stale data cannot pass
	function automatic logic [31:0] next_pair(input logic [7:0] b0, input logic [7:0] b1,
		input logic two);
		logic [7:0] sec;
		sec = two ? b1 : ~last_q[15:8];
		last_q = {sec, b0};
		return {16'h0000, sec, b0};
	endfunction : next_pair
endmodule : opd_fetch_model

// File: bench/tb_opd_decoder.sv
// testbench for the opcode decoder
`timescale 1ns/1ps
module tb_opd_decoder;
	logic        aclk, aresetn;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          bad_count = 0;
	int          check_count = 0;
	opd_decoder opd_decoder_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	opd_fetch_model opd_fetch_model_i ();
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// ==========
	// bus and compare helpers
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// waits for the answer however long it takes; only the watchdog ends a hang
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	// one byte pair in, result compared as valid, operation and length
	task automatic dec(input logic [7:0] b0, input logic [7:0] b1, input logic [5:0] op,
		input logic [2:0] len);
		axw(4'h4, opd_fetch_model_i.next_pair(b0, b1, len != 3'h1), rs);
		check("wr_resp", rs, 2'h0);
		repeat (2) @(posedge aclk);
		axr(4'h8, rd, rs);
		check("decode", {rd[20:14], rd[2:0]}, {len != 3'h0, op, len});
		check("rd_resp", rs, 2'h0);
	endtask : dec
	// ==========
	// scenarios
	task automatic t_regs;
		axr(4'h0, rd, rs); check("ctrl_reset", rd, 32'h0);
		axw(4'h8, 32'h1, rs); check("ro_write", rs, 2'h2);
		axr(4'h2, rd, rs); check("odd_read", rs, 2'h2);
		axw(4'h0, 32'h1, rs); axr(4'h0, rd, rs); check("ctrl", rd[0], 1'h1);
	endtask : t_regs
	task automatic t_transfer;
		dec(8'h8E, 8'h18, 6'h01, 3'h2); check("seg_sel", rd[8:6], 3'h3);
		dec(8'h8E, 8'h20, 6'h00, 3'h0);
		dec(8'h8C, 8'h26, 6'h00, 3'h0);
		dec(8'h8C, 8'hC8, 6'h02, 3'h2); check("reg_form", rd[9], 1'h1);
		dec(8'hD7, 8'h00, 6'h03, 3'h1);
		dec(8'h8D, 8'h06, 6'h04, 3'h4); check("mem_form", rd[9], 1'h0);
		dec(8'h8D, 8'h00, 6'h04, 3'h2);
		dec(8'hC5, 8'h40, 6'h05, 3'h3);
		dec(8'hC4, 8'h80, 6'h06, 3'h4);
		dec(8'h9F, 8'h00, 6'h07, 3'h1);
		dec(8'h9E, 8'h00, 6'h08, 3'h1);
	endtask : t_transfer
	task automatic t_arith;
		dec(8'h13, 8'hC0, 6'h09, 3'h2); check("to_reg", rd[12], 1'h1);
		dec(8'h28, 8'h00, 6'h0A, 3'h2); check("dir_w", rd[13:12], 2'h0);
		dec(8'h1B, 8'hC0, 6'h0B, 3'h2);
		dec(8'h1C, 8'h00, 6'h0C, 3'h2);
		dec(8'h1D, 8'h00, 6'h0C, 3'h3); check("word", rd[13], 1'h1);
		dec(8'h37, 8'h00, 6'h0D, 3'h1);
		dec(8'h3F, 8'h00, 6'h0E, 3'h1);
		dec(8'h2F, 8'h00, 6'h0F, 3'h1);
		dec(8'hD4, 8'h0A, 6'h10, 3'h2);
		dec(8'hD5, 8'h0A, 6'h11, 3'h2);
		dec(8'hD4, 8'h0B, 6'h00, 3'h0);
	endtask : t_arith
	task automatic t_groups;
		for (int m = 0; m < 8; m++) begin
			if (m != 1) dec(8'hF7, 8'(8'hC0 + m * 8), m == 0 ? 6'h12 : 6'(6'h11 + m),
				m == 0 ? 3'h4 : 3'h2);
			if (m != 6) dec(8'hD3, 8'(8'hC0 + m * 8), m == 7 ? 6'h1F : 6'(6'h19 + m),
				3'h2);
		end
		check("by_count", rd[11], 1'h1);
		dec(8'hD3, 8'hF0, 6'h00, 3'h0);
		dec(8'hF6, 8'hC0, 6'h12, 3'h3);
		dec(8'hF7, 8'hC8, 6'h00, 3'h0);
		dec(8'hD0, 8'h00, 6'h19, 3'h2); check("by_one", rd[11], 1'h0);
	endtask : t_groups
	task automatic t_misc;
		dec(8'h98, 8'h00, 6'h20, 3'h1);
		dec(8'h99, 8'h00, 6'h21, 3'h1);
		dec(8'hA5, 8'h00, 6'h22, 3'h1);
		dec(8'hA7, 8'h00, 6'h23, 3'h1);
		dec(8'hAF, 8'h00, 6'h24, 3'h1);
		dec(8'hAD, 8'h00, 6'h25, 3'h1);
		dec(8'hAB, 8'h00, 6'h26, 3'h1);
		dec(8'hF3, 8'h00, 6'h27, 3'h1);
		dec(8'hA4, 8'h00, 6'h22, 3'h1); check("byte", rd[13], 1'h0);
		dec(8'hF2, 8'h00, 6'h27, 3'h1);
	endtask : t_misc
	// 45 distinct valid decodes so far; a held capture must not count more
	task automatic t_hold;
		axr(4'hC, rd, rs); check("status", rd, 32'h2D);
		axw(4'h0, 32'h0, rs);
		axw(4'h4, opd_fetch_model_i.next_pair(8'h98, 8'h00, 1'b0), rs);
		repeat (2) @(posedge aclk);
		axr(4'h8, rd, rs); check("held", rd[19:14], 6'h27);
		axr(4'hC, rd, rs); check("status_held", rd, 32'h2D);
	endtask : t_hold
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	// ==========
	// main sequence and watchdog
	initial begin
		aresetn = 1'b0; s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0; s_axi_wstrb = 4'h0;
		s_axi_wdata = 32'h0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_transfer();
		t_arith();
		t_groups();
		t_misc();
		t_hold();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		report_and_stop();
	end
endmodule : tb_opd_decoder
